// >>> pio_pkg.sv
/*
 * Package for the parallel I/O port block: port geometry, register
 * offsets, reset values and the carrier structs shared by the block.
 * Assumes a byte-wide register port driven from the CPU bus.
 */
package pio_pkg;
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 5;
    // register offsets: data at 0x00+p, direction at 0x08+p, pullup at 0x10+p
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_DIR = 5'h08;
    localparam logic [4:0] OFS_PULL = 5'h10;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PULL_RESET = 8'h00;
    // pins present per port (A..G)
    localparam logic [7:0] PIN_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF,
                                                    8'h3F, 8'hFF, 8'hFF};
    // ports with pullups: A, C, D, F
    localparam logic [NUM_PORTS-1:0] HAS_PULL = 7'h2D;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pio_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pio_pad_t;
endpackage

// >>> pio_ports.sv
/*
 * Seven parallel bidirectional ports with direction, data latch,
 * pullup control on ports A C D F and peripheral override per pin.
 * Assumes synchronous pin inputs and a single-cycle register master.
 */
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - seven separate bidirectional parallel ports
// RL2 - each pin programmable input or output
// RL3 - pullups selectable on ports A C D F
// RL4 - pullup off while pin drives output
// RL5 - port A eight bits, shared pins
// RL6 - port A latch per pin
// RL7 - software terminates unused pins itself
// RL8 - direction one drives; reset clears direction
// RL9 - read returns latch or pin level
// RL10 - writes always update latch; reset keeps
// RL11 - claiming module overrides port logic
module pio_ports (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire pio_pkg::pio_req_t req,
    output logic [7:0] rdata,
    input wire logic [7:0] pin_in [pio_pkg::NUM_PORTS],
    output pio_pkg::pio_pad_t pad [pio_pkg::NUM_PORTS],
    input wire logic [7:0] mod_claim [pio_pkg::NUM_PORTS],
    input wire logic [7:0] mod_out [pio_pkg::NUM_PORTS],
    input wire logic [7:0] mod_oe [pio_pkg::NUM_PORTS]
);

////////////////////////////////////////////////////////////////////////
    logic [7:0] data_latch [pio_pkg::NUM_PORTS];
    logic [7:0] dir_bits [pio_pkg::NUM_PORTS];
    logic [7:0] pull_en [pio_pkg::NUM_PORTS];

    // port index in the low bits, group in the upper two
    function automatic logic hit(input logic [4:0] a, input logic [4:0] base,
                                 input int p);
        hit = (a == base + 5'(p));
    endfunction

////////////////////////////////////////////////////////////////////////
    // RL1 seven port slices
    for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++)
    begin : g_port
        // RL10 latch no reset
        // RL6 one latch per pin
        always_ff @(posedge ref_clk)
        begin
            if (req.wr && hit(req.addr, pio_pkg::OFS_DATA, p))
            begin
                data_latch[p] <= req.wdata & pio_pkg::PIN_MASK[p];
            end
        end

        // RL8 direction reset clear
        // RL2 per pin direction
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                dir_bits[p] <= pio_pkg::DIR_RESET;
            end
            else if (req.wr && hit(req.addr, pio_pkg::OFS_DIR, p))
            begin
                dir_bits[p] <= req.wdata & pio_pkg::PIN_MASK[p];
            end
        end

        // RL3 pullup select register
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                pull_en[p] <= pio_pkg::PULL_RESET;
            end
            else if (pio_pkg::HAS_PULL[p] && req.wr && hit(req.addr, pio_pkg::OFS_PULL, p))
            begin
                pull_en[p] <= req.wdata & pio_pkg::PIN_MASK[p];
            end
        end

        // RL11 module precedence
        // RL5 port A shared pins
        always_comb
        begin
            pad[p].oe = ((mod_claim[p] & mod_oe[p]) | (~mod_claim[p] & dir_bits[p]))
                        & pio_pkg::PIN_MASK[p];
            pad[p].out = (mod_claim[p] & mod_out[p]) | (~mod_claim[p] & data_latch[p]);
            // RL4 pullup off on output
            pad[p].pull = pio_pkg::HAS_PULL[p] ? (pull_en[p] & ~pad[p].oe) : 8'h00;
        end
    end

////////////////////////////////////////////////////////////////////////
    // RL9 latch or pin read
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= 8'h00;
            for (int p = 0; p < pio_pkg::NUM_PORTS; p++)
            begin
                if (req.rd && hit(req.addr, pio_pkg::OFS_DATA, p))
                begin
                    rdata <= ((dir_bits[p] & data_latch[p]) | (~dir_bits[p] & pin_in[p]))
                             & pio_pkg::PIN_MASK[p];
                end
                else if (req.rd && hit(req.addr, pio_pkg::OFS_DIR, p))
                begin
                    rdata <= dir_bits[p];
                end
                else if (req.rd && hit(req.addr, pio_pkg::OFS_PULL, p))
                begin
                    rdata <= pull_en[p];
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////
    // RL8 reset makes port A all inputs
    a_reset_dir_clear: assert property (@(posedge ref_clk) // RL8
        $rose(rst_b) |-> dir_bits[0] == 8'h00)
        else $error("direction not cleared by reset");

    // RL4 pullup off driving
    a_pull_drop_out: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
        (pad[0].oe != 8'h00) |-> ((pad[0].pull & pad[0].oe) == 8'h00))
        else $error("pullup active on driving pin");

    // RL2 direction write lands
    a_dir_write_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
        (req.wr && req.addr == pio_pkg::OFS_DIR) |=> dir_bits[0] == $past(req.wdata))
        else $error("direction write lost");

    // RL10 latch write lands
    a_latch_write_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
        (req.wr && req.addr == pio_pkg::OFS_DATA) |=> data_latch[0] == $past(req.wdata))
        else $error("latch write lost");

    // RL9 input pin read
    a_read_pin_in: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
        (req.rd && req.addr == pio_pkg::OFS_DATA && dir_bits[0] == 8'h00)
        |=> rdata == $past(pin_in[0]))
        else $error("input read wrong");

    // RL9 output latch read
    a_read_latch_out: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
        (req.rd && req.addr == pio_pkg::OFS_DATA && dir_bits[0] == 8'hFF && !req.wr)
        |=> rdata == $past(data_latch[0]))
        else $error("output read wrong");

    // RL11 claimed bits follow module
    a_claim_over_dir: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
        ((pad[0].oe ^ mod_oe[0]) & mod_claim[0]) == 8'h00)
        else $error("module claim ignored");

    // RL3 no pullup on port B
    a_no_pull_b: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
        pad[1].pull == 8'h00)
        else $error("pullup on port without pullups");

    // RL9 idle read data low
    a_read_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
        !req.rd |=> rdata == 8'h00)
        else $error("read data not cleared");

////////////////////////////////////////////////////////////////////////
    // per-port checks; the latch is unknown until written, so
    // anything that looks at it waits for a write first, except a_read_latch
    for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++)
    begin : g_chk
        sequence s_dir_wr;
            req.wr && hit(req.addr, pio_pkg::OFS_DIR, p);
        endsequence
        sequence s_data_wr;
            req.wr && hit(req.addr, pio_pkg::OFS_DATA, p);
        endsequence
        sequence s_pull_wr;
            req.wr && hit(req.addr, pio_pkg::OFS_PULL, p);
        endsequence
        sequence s_dir_rd;
            req.rd && hit(req.addr, pio_pkg::OFS_DIR, p);
        endsequence
        sequence s_data_rd;
            req.rd && hit(req.addr, pio_pkg::OFS_DATA, p);
        endsequence
        sequence s_pull_rd;
            req.rd && hit(req.addr, pio_pkg::OFS_PULL, p);
        endsequence

        // RL2 direction write lands
        a_dir_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
            s_dir_wr |=> dir_bits[p] == ($past(req.wdata) & pio_pkg::PIN_MASK[p]))
            else $error("direction write lost on port");

        // RL2 direction holds otherwise
        a_dir_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
            !(req.wr && hit(req.addr, pio_pkg::OFS_DIR, p)) |=> $stable(dir_bits[p]))
            else $error("direction changed without write");

        // RL2 absent pins never output
        a_dir_mask: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
            (dir_bits[p] & ~pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("direction set on absent pin");

        // RL10 latch write any direction
        a_latch_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
            s_data_wr |=> data_latch[p] == ($past(req.wdata) & pio_pkg::PIN_MASK[p]))
            else $error("latch write lost on port");

        // RL6 latch only for present pins
        a_latch_mask: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
            s_data_wr |=> (data_latch[p] & ~pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("latch bit on absent pin");

        // RL9 direction read back
        a_read_dir: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
            s_dir_rd |=> rdata == $past(dir_bits[p]))
            else $error("direction read wrong");

        // RL9 input bits show pin
        a_read_pin: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
            s_data_rd |=> ((rdata ^ $past(pin_in[p])) & ~$past(dir_bits[p])
                & pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("input bit read wrong");

        // RL9 output bits show latch
        a_read_latch: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
            s_data_rd |=> ((rdata ^ $past(data_latch[p])) & $past(dir_bits[p])) == 8'h00)
            else $error("output bit read wrong");

        // RL9 absent pins read zero
        a_read_unused: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
            s_data_rd |=> (rdata & ~pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("absent pin read nonzero");

        // RL11 claimed enable from module
        a_claim_oe: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
            ((pad[p].oe ^ mod_oe[p]) & mod_claim[p] & pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("claimed enable wrong");

        // RL11 claimed value from module
        a_claim_out: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
            ((pad[p].out ^ mod_out[p]) & mod_claim[p]) == 8'h00)
            else $error("claimed value wrong");

        // RL2 free pins follow direction
        a_free_oe: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
            ((pad[p].oe ^ dir_bits[p]) & ~mod_claim[p]) == 8'h00)
            else $error("free pin enable wrong");

        // RL10 free pins drive latch
        a_free_out: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
            s_data_wr |=> ((pad[p].out ^ $past(req.wdata)) & ~mod_claim[p]
                & pio_pkg::PIN_MASK[p]) == 8'h00)
            else $error("free pin value wrong");

        // RL8 reset leaves inputs unpulled
        a_reset_clear: assert property (@(posedge ref_clk) // RL8
            $rose(rst_b) |-> (dir_bits[p] == 8'h00) && (pull_en[p] == 8'h00))
            else $error("port not cleared by reset");

        // RL4 no pullup while driving
        a_pull_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
            (pad[p].pull & pad[p].oe) == 8'h00)
            else $error("pullup on driving pin");

        if (pio_pkg::HAS_PULL[p])
        begin : g_pull
            // RL3 pullup write lands
            a_pull_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
                s_pull_wr |=> pull_en[p] == ($past(req.wdata) & pio_pkg::PIN_MASK[p]))
                else $error("pullup write lost");

            // RL4 pullup back on input
            a_pull_back: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
                (pull_en[p] & ~pad[p].oe) == pad[p].pull)
                else $error("pullup not restored on input");

            // RL3 pullup read back
            a_read_pull: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
                s_pull_rd |=> rdata == $past(pull_en[p]))
                else $error("pullup read wrong");
        end
        else
        begin : g_nopull
            // RL3 no pullup on this port
            a_pull_none: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
                (pull_en[p] == 8'h00) && (pad[p].pull == 8'h00))
                else $error("pullup on port without pullups");

            // RL3 absent pullup reads zero
            a_pull_none_rd: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
                s_pull_rd |=> rdata == 8'h00)
                else $error("absent pullup read nonzero");
        end
    end
endmodule
`default_nettype wire

// >>> pio_board.sv
/* pin-side board model for the port block.
   assumes pads from pio_ports and a bench-set level for undriven pins. */
`timescale 1ns/1ps
`default_nettype none
module pio_board (
    input wire pio_pkg::pio_pad_t pad [pio_pkg::NUM_PORTS],
    input wire logic [7:0] ext [pio_pkg::NUM_PORTS],
    output logic [7:0] lvl [pio_pkg::NUM_PORTS]
);
    // unused pins not terminated here; they follow the board level
    // driven pin wins, then pullup, else the board level
    always_comb
    begin
        for (int p = 0; p < pio_pkg::NUM_PORTS; p++)
        begin
            lvl[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe & (pad[p].pull | ext[p]));
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
/* self-checking bench for pio_ports.
   assumes 100 MHz ref_clk and the one-cycle register port of the notes. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic ref_clk = 0;
    logic rst_b = 0;
    pio_pkg::pio_req_t req = '0;
    logic [7:0] rdata;
    logic [7:0] lvl [pio_pkg::NUM_PORTS];
    pio_pkg::pio_pad_t pad [pio_pkg::NUM_PORTS];
    logic [7:0] ext [pio_pkg::NUM_PORTS] = '{default: 8'h00};
    logic [7:0] claim [pio_pkg::NUM_PORTS] = '{default: 8'h00};
    logic [7:0] mout [pio_pkg::NUM_PORTS] = '{default: 8'h00};
    logic [7:0] moe [pio_pkg::NUM_PORTS] = '{default: 8'h00};
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    pio_ports i_pio_ports (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .pin_in(lvl), .pad(pad), .mod_claim(claim), .mod_out(mout), .mod_oe(moe));
    pio_board i_pio_board (.pad(pad), .ext(ext), .lvl(lvl));
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req.addr <= a; req.wdata <= d; req.wr <= 1'b1;
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic cr(input logic [4:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req.addr <= a; req.rd <= 1'b1;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        logic [7:0] m;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int p = 0; p < pio_pkg::NUM_PORTS; p++)
        begin
            m = pio_pkg::PIN_MASK[p];
            cr(pio_pkg::OFS_DIR + 5'(p), 8'h00);
            cr(pio_pkg::OFS_PULL + 5'(p), 8'h00);
            wr(pio_pkg::OFS_DATA + 5'(p), 8'hA5);
            wr(pio_pkg::OFS_DIR + 5'(p), 8'hFF);
            wr(pio_pkg::OFS_PULL + 5'(p), 8'hFF);
            cr(pio_pkg::OFS_DATA + 5'(p), 8'hA5 & m);
            `CHK({pad[p].oe, pad[p].out, pad[p].pull}, {m, 8'hA5 & m, 8'h00})
            cr(pio_pkg::OFS_PULL + 5'(p), pio_pkg::HAS_PULL[p] ? m : 8'h00);
            ext[p] <= 8'h3C;
            wr(pio_pkg::OFS_DIR + 5'(p), 8'h00);
            repeat (3) @(posedge ref_clk);
            cr(pio_pkg::OFS_DATA + 5'(p), (pio_pkg::HAS_PULL[p] ? 8'hFF : 8'h3C) & m);
            wr(pio_pkg::OFS_PULL + 5'(p), 8'h00);
            wr(pio_pkg::OFS_DATA + 5'(p), 8'h0F);
            repeat (3) @(posedge ref_clk);
            cr(pio_pkg::OFS_DATA + 5'(p), 8'h3C & m);
            wr(pio_pkg::OFS_DIR + 5'(p), 8'hFF);
            cr(pio_pkg::OFS_DATA + 5'(p), 8'h0F & m);
        end
        cr(5'h18, 8'h00);
        $display("port tests done");
        claim[0] <= 8'h03;
        moe[0] <= 8'h02;
        mout[0] <= 8'h01;
        @(posedge ref_clk);
        #1 `CHK({pad[0].oe, pad[0].out}, {8'hFE, 8'h0D})
        $display("claim test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        cr(pio_pkg::OFS_DIR, 8'h00);
        wr(pio_pkg::OFS_DIR, 8'hFF);
        cr(pio_pkg::OFS_DATA, 8'h0F);
        $display("reset test done");
        final_report;
    end
    // full run is well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        final_report;
    end
endmodule
`default_nettype wire
